// ---- core/i2c_state_trace_and_mode.sv ----
// i2c state trace readback, operating config register and dma/irq steering
//
// Overview of operation
// - main states 0-4, 6, 7 report sub-state zero
// - master start state reports sub-state zero for a fresh transaction
// - master start state reports sub-state one on a repeated start
// - byte states report bit index seven down to zero, then eight for acknowledge
// - eight-bit read/write operating config register, reset zero, fixed field layout
// - dma select clear: tx empty and rx full raise the interrupt
// - dma select set: tx empty and rx full flags still update normally
// - dma select set: tx empty and rx full never raise the interrupt
// - dma select set: interrupt shows errors only; flags raise dma requests
// - diagnostic set: state read returns main and sub nibbles; else status
// - mode field picks master/slave or slave-only, seven or ten bit address
// - each byte state walks nine sub-states: eight bits plus acknowledge
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module i2c_state_trace_and_mode
  import i2c_trace_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [3:0] main_state_nibble,
  input wire logic [2:0] eng_bit_index,
  input wire logic eng_ack_phase,
  input wire logic eng_restart,
  input wire logic [7:0] eng_status,
  input wire logic tx_holding_empty,
  input wire logic rx_holding_full,
  input wire logic eng_error,
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req,
  output logic dma_handoff_select,
  output logic slave_only,
  output logic ten_bit_addr,
  output logic interactive_receive,
  output logic general_call_accept,
  output logic [1:0] own_addr_upper_bits,
  output logic diagnostic_readback_sel
);

  // ==========================================================
  // sub-state encoding
  logic [3:0] sub_state_nibble;

  always_comb
  begin
    sub_state_nibble = SUB_NONE;
    if (main_state_nibble == MAIN_MASTER_START)
    begin
      sub_state_nibble = eng_restart ? SUB_RESTART : SUB_NONE;
    end
    else if (main_state_nibble >= MAIN_FIRST_BYTE)
    begin
      // nine steps per byte: bit 7..0 then acknowledge
      sub_state_nibble = eng_ack_phase ? SUB_ACK : {1'b0, eng_bit_index};
    end
  end

  // ==========================================================
  // ahb-lite address and data phase
  logic [7:0] config_r;
  logic wr_pend_r;
  logic [31:0] wr_addr_r;
  logic addr_phase;
  logic cfg_fwd;
  logic [7:0] cfg_view;
  logic [31:0] rdata_nxt;

  assign addr_phase = hsel && hready && htrans[1];
  // a read right behind a write to the config register sees the new value
  assign cfg_fwd = wr_pend_r && (wr_addr_r == CONFIG_REG_ADDR);
  assign cfg_view = cfg_fwd ? hwdata[7:0] : config_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= RDATA_ZERO;
    end
    else if (hready)
    begin
      wr_pend_r <= addr_phase && hwrite;
      wr_addr_r <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      config_r <= CONFIG_RESET;
    end
    else if (cfg_fwd)
    begin
      config_r <= hwdata[7:0];
    end
  end

  always_comb
  begin
    rdata_nxt = RDATA_ZERO;
    if (haddr == STATE_REG_ADDR)
    begin
      // pure view of engine state, nothing is cleared by the read
      if (cfg_view[DIAGNOSTIC_READBACK_SEL_BIT])
      begin
        rdata_nxt[7:0] = {main_state_nibble, sub_state_nibble};
      end
      else
      begin
        rdata_nxt[7:0] = eng_status;
      end
    end
    else if (haddr == CONFIG_REG_ADDR)
    begin
      rdata_nxt[7:0] = cfg_view;
    end
    else if (haddr == FLAG_VIEW_ADDR)
    begin
      rdata_nxt[FV_TX_EMPTY] = tx_holding_empty;
      rdata_nxt[FV_RX_FULL] = rx_holding_full;
      rdata_nxt[FV_ERROR] = eng_error;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= RDATA_ZERO;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
    else
    begin
      // zero wait states: data phase always completes at once
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      if (addr_phase && !hwrite)
      begin
        hrdata <= rdata_nxt;
      end
    end
  end

  // ==========================================================
  // interrupt and dma steering
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end
    else if (config_r[DMA_SEL_BIT])
    begin
      irq <= eng_error;
      tx_dma_req <= tx_holding_empty;
      rx_dma_req <= rx_holding_full;
    end
    else
    begin
      irq <= eng_error || tx_holding_empty || rx_holding_full;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end
  end

  // ==========================================================
  // config field outputs, the protocol engine acts on these
  assign dma_handoff_select = config_r[DMA_SEL_BIT];
  assign slave_only = config_r[MODE_HI_BIT];
  assign ten_bit_addr = config_r[MODE_LO_BIT];
  assign interactive_receive = config_r[IRM_BIT];
  assign general_call_accept = config_r[GCA_BIT];
  assign own_addr_upper_bits = config_r[UPPER_HI_BIT:UPPER_LO_BIT];
  assign diagnostic_readback_sel = config_r[DIAGNOSTIC_READBACK_SEL_BIT];

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_state_read;
    addr_phase && !hwrite && (haddr == STATE_REG_ADDR) && diagnostic_readback_sel && !cfg_fwd;
  endsequence

  sequence seq_cfg_write;
    addr_phase && hwrite && (haddr == CONFIG_REG_ADDR) ##1 hready;
  endsequence

  chk_quiet_states: assert property (
    (main_state_nibble < MAIN_MASTER_START || main_state_nibble == 4'h6
      || main_state_nibble == 4'h7) |-> sub_state_nibble == SUB_NONE)
    else $error("sub-state not zero in a state without sub-states");

  chk_start_restart: assert property (
    main_state_nibble == MAIN_MASTER_START
      |-> sub_state_nibble == (eng_restart ? SUB_RESTART : SUB_NONE))
    else $error("wrong start/restart sub-state");

  chk_byte_substate: assert property (
    main_state_nibble >= MAIN_FIRST_BYTE && !eng_ack_phase
      |-> sub_state_nibble == {1'b0, eng_bit_index})
    else $error("byte sub-state does not match bit index");

  chk_ack_substate: assert property (
    main_state_nibble >= MAIN_FIRST_BYTE && eng_ack_phase |-> sub_state_nibble == SUB_ACK)
    else $error("acknowledge sub-state not eight");

  chk_cfg_write: assert property (
    seq_cfg_write |=> config_r == $past(hwdata[7:0]))
    else $error("config write not stored");

  chk_diagnostic_readback_sel_read: assert property (
    seq_state_read |=> hrdata[7:0] == {$past(main_state_nibble), $past(sub_state_nibble)})
    else $error("diagnostic state read wrong");

  chk_dma_irq_quiet: assert property (
    dma_handoff_select && !eng_error ##1 dma_handoff_select |-> !irq)
    else $error("interrupt raised by flags in dma mode");

  chk_dma_request: assert property (
    dma_handoff_select && tx_holding_empty |=> tx_dma_req || !dma_handoff_select)
    else $error("transmit dma request missing");

  chk_rx_request: assert property (
    dma_handoff_select && rx_holding_full |=> rx_dma_req)
    else $error("receive dma request missing");

  chk_poll_irq: assert property (
    !dma_handoff_select && (tx_holding_empty || rx_holding_full) |=> irq || dma_handoff_select)
    else $error("flag did not raise interrupt");

  chk_bus_okay: assert property (
    hreadyout && hresp == HRESP_OKAY)
    else $error("slave stalled or errored");

endmodule : i2c_state_trace_and_mode
`default_nettype wire

// ---- core/i2c_trace_pkg.sv ----
// constants for the i2c state trace and operating config block
package i2c_trace_pkg;
  // register indices, byte address is four times the index
  localparam logic [31:0] STATE_REG_IDX = 32'h00ff_e245;
  localparam logic [31:0] CONFIG_REG_IDX = 32'h00ff_e246;
  localparam logic [31:0] FLAG_VIEW_IDX = 32'h00ff_e24f;
  localparam logic [31:0] STATE_REG_ADDR = {STATE_REG_IDX[29:0], 2'b00};
  localparam logic [31:0] CONFIG_REG_ADDR = {CONFIG_REG_IDX[29:0], 2'b00};
  localparam logic [31:0] FLAG_VIEW_ADDR = {FLAG_VIEW_IDX[29:0], 2'b00};

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // operating config field positions
  localparam int DMA_SEL_BIT = 7;
  localparam int MODE_HI_BIT = 6;
  localparam int MODE_LO_BIT = 5;
  localparam int IRM_BIT = 4;
  localparam int GCA_BIT = 3;
  localparam int UPPER_HI_BIT = 2;
  localparam int UPPER_LO_BIT = 1;
  localparam int DIAGNOSTIC_READBACK_SEL_BIT = 0;

  // operating mode encodings
  localparam logic [1:0] MODE_MS_7BIT = 2'h0;
  localparam logic [1:0] MODE_MS_10BIT = 2'h1;
  localparam logic [1:0] MODE_SLV_7BIT = 2'h2;
  localparam logic [1:0] MODE_SLV_10BIT = 2'h3;

  // main state nibble values of interest
  localparam logic [3:0] MAIN_MASTER_START = 4'h5;
  localparam logic [3:0] MAIN_FIRST_BYTE = 4'h8;
  // sub state values
  localparam logic [3:0] SUB_NONE = 4'h0;
  localparam logic [3:0] SUB_RESTART = 4'h1;
  localparam logic [3:0] SUB_ACK = 4'h8;

  // flag view bit positions
  localparam int FV_TX_EMPTY = 0;
  localparam int FV_RX_FULL = 1;
  localparam int FV_ERROR = 2;

  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : i2c_trace_pkg

// ---- testbench/i2c_engine_model.sv ----
// engine side stand-in driving controller state, status and flags
`timescale 1ns/1ns
`default_nettype none
module i2c_engine_model
(
  input wire logic hclk,
  output logic [3:0] main_state_nibble,
  output logic [2:0] eng_bit_index,
  output logic eng_ack_phase,
  output logic eng_restart,
  output logic [7:0] eng_status,
  output logic tx_holding_empty,
  output logic rx_holding_full,
  output logic eng_error
);
  // =====
  // step k: 0..7 walks bits msb first, 8 is the acknowledge
  // restart toggles in every state, so only state 5 may honour it
  task automatic put(input logic [3:0] s, input logic [3:0] k, input logic [2:0] f);
    // engine outputs move only on the system clock, as the real engine's do
    @(posedge hclk);
    main_state_nibble <= s;
    eng_bit_index <= 3'(4'h7 - k);
    eng_ack_phase <= (k == 4'h8);
    eng_restart <= k[0];
    eng_status <= ~{s, k};
    {eng_error, rx_holding_full, tx_holding_empty} <= f;
  endtask : put

  initial
  begin
    put(4'h0, 4'h0, 3'h0);
  end
endmodule : i2c_engine_model
`default_nettype wire

// ---- testbench/i2c_state_trace_and_mode_tb.sv ----
// self-checking bench for the state trace and operating config block
`timescale 1ns/1ns
`default_nettype none
module i2c_state_trace_and_mode_tb;
  import i2c_trace_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, tx_dma_req, rx_dma_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, own_addr_upper_bits;
  logic [2:0] hsize, eng_bit_index;
  logic [3:0] main_state_nibble;
  logic [7:0] eng_status;
  logic dma_handoff_select, slave_only, ten_bit_addr, interactive_receive;
  logic general_call_accept, diagnostic_readback_sel, eng_ack_phase, eng_restart;
  logic tx_holding_empty, rx_holding_full, eng_error;
  int errors, comparisons;

  i2c_state_trace_and_mode u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .main_state_nibble, .eng_bit_index, .eng_ack_phase, .eng_restart, .eng_status,
    .tx_holding_empty, .rx_holding_full, .eng_error, .irq, .tx_dma_req, .rx_dma_req,
    .dma_handoff_select, .slave_only, .ten_bit_addr, .interactive_receive,
    .general_call_accept, .own_addr_upper_bits, .diagnostic_readback_sel);
  i2c_engine_model u_eng (.hclk, .main_state_nibble, .eng_bit_index, .eng_ack_phase,
    .eng_restart, .eng_status, .tx_holding_empty, .rx_holding_full, .eng_error);

  // =====
  // bus tasks
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // bounded wait for hready at a rising edge
  task automatic edge_ready();
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        errors++;
        tally_and_finish();
      end
      @(posedge hclk);
    end
  endtask : edge_ready

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    edge_ready();
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    edge_ready();
    rd = hrdata;
  endtask : bus

  // =====
  // clock and sequence
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    errors = 0;
    comparisons = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, CONFIG_REG_ADDR, 32'h0000_0000);
    chk("config reset", 32'h0000_0000, rd);
    bus(1'b1, CONFIG_REG_ADDR, 32'h0000_00fe);
    bus(1'b0, CONFIG_REG_ADDR, 32'h0000_0000);
    chk("config rw", 32'h0000_00fe, rd);
    chk("config pins", 32'h0000_00fe, {24'h0, dma_handoff_select, slave_only, ten_bit_addr,
      interactive_receive, general_call_accept, own_addr_upper_bits,
      diagnostic_readback_sel});
    bus(1'b0, 32'h0000_0100, 32'h0000_0000);
    chk("unmapped", RDATA_ZERO, rd);
    chk("okay response", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, CONFIG_REG_ADDR, 32'(m * 32 + 1));
      @(posedge hclk);
      chk("mode", 32'(m * 2 + 1),
        {29'h0, slave_only, ten_bit_addr, diagnostic_readback_sel});
    end
    // diagnostic readback of every state and step
    for (int s = 0; s < 16; s++)
      for (int k = 0; k < 9; k++)
      begin
        u_eng.put(4'(s), 4'(k), 3'h0);
        bus(1'b0, STATE_REG_ADDR, 32'h0000_0000);
        chk("state", {24'h0, 4'(s), s == 5 ? 4'(k % 2) : s > 7 ?
          4'(k == 8 ? 8 : 7 - k) : 4'h0}, rd);
      end
    bus(1'b1, CONFIG_REG_ADDR, 32'h0000_0000);
    u_eng.put(4'h9, 4'h3, 3'h0);
    bus(1'b0, STATE_REG_ADDR, 32'h0000_0000);
    chk("status", 32'h0000_006c, rd);
    for (int d = 0; d < 2; d++)
    begin
      bus(1'b1, CONFIG_REG_ADDR, 32'(d * 128));
      for (int v = 0; v < 8; v++)
      begin
        u_eng.put(4'h0, 4'h0, 3'(v));
        bus(1'b0, FLAG_VIEW_ADDR, 32'h0000_0000);
        chk("flags", 32'(v), rd);
        chk("irq dma", {29'h0, 1'(d ? v / 4 : v != 0), 1'(d & v / 2), 1'(d & v)},
          {29'h0, irq, rx_dma_req, tx_dma_req});
      end
    end
    // second reset in mid-run: config and steering outputs return to zero
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    chk("reset outputs", 32'h0000_0000, {29'h0, irq, rx_dma_req, tx_dma_req});
    chk("reset pins", 32'h0000_0000, {24'h0, dma_handoff_select, slave_only, ten_bit_addr,
      interactive_receive, general_call_accept, own_addr_upper_bits,
      diagnostic_readback_sel});
    bus(1'b0, CONFIG_REG_ADDR, 32'h0000_0000);
    chk("config after reset", 32'h0000_0000, rd);
    tally_and_finish();
  end
endmodule : i2c_state_trace_and_mode_tb
`default_nettype wire
